// [core/tra_pkg.sv]
package tra_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_LOCAL_TEMP   = 8'h00;
   localparam logic [7:0] OFS_REM1_SIGNED  = 8'h04;
   localparam logic [7:0] OFS_REM2_SIGNED  = 8'h08;
   localparam logic [7:0] OFS_REM1_UNSIGN  = 8'h0c;
   localparam logic [7:0] OFS_REM2_UNSIGN  = 8'h10;
   localparam logic [7:0] OFS_CONFIG       = 8'h14;
   localparam logic [7:0] OFS_FAULT_STAT   = 8'h18;
   localparam logic [7:0] OFS_ALARM_STAT   = 8'h1c;
   localparam logic [7:0] OFS_MASK         = 8'h20;
   localparam logic [7:0] OFS_LIMIT_LOCAL  = 8'h24;
   localparam logic [7:0] OFS_LIMIT_REM1   = 8'h28;
   localparam logic [7:0] OFS_LIMIT_REM2   = 8'h2c;
   localparam logic [7:0] OFS_HYST         = 8'h30;
   localparam logic [7:0] OFS_ID           = 8'h34;
   // config fields: channel enables [2:0], filter enables [4:3]
   localparam int CFG_EN_LOCAL  = 0;
   localparam int CFG_EN_REM1   = 1;
   localparam int CFG_EN_REM2   = 2;
   localparam int CFG_FILT_REM1 = 3;
   localparam int CFG_FILT_REM2 = 4;
   localparam logic [4:0] CONFIG_RESET = 5'h1f;
   // fault status bits
   localparam int FAULT_REM1_BIT = 1;
   localparam int FAULT_REM2_BIT = 0;
   // alarm status field bases (3 bits per output: local, rem1, rem2)
   localparam int STAT_ALARM1_BASE = 0;
   localparam int STAT_ALARM2_BASE = 3;
   localparam int STAT_ALARM3_BASE = 6;
   localparam logic [8:0] MASK_RESET = 9'h1c1;
   // limits in whole degrees
   localparam logic [7:0] LIMIT_LOCAL_RESET = 8'h55;
   localparam logic [7:0] LIMIT_HIGH_RESET  = 8'h6e;
   localparam logic [7:0] LIMIT_LOW_RESET   = 8'h55;
   localparam logic [7:0] HYST_RESET        = 8'h05;
   // identity code, arbitrary value
   localparam logic [15:0] ID_VALUE = 16'h5a3c;
   // format constants
   localparam logic [15:0] UNSIGNED_FULL   = 16'hffe0;
   localparam logic [15:0] SIGNED_FAULT    = 16'h8000;
   localparam logic [15:0] COARSE_MASK     = 16'hffe0;
   localparam logic [15:0] FINE_MASK       = 16'hfff8;
endpackage

// [core/tra_temp_alarm.sv]
// Contract
// R1 - unfiltered unsigned remote: 11 bits left-justified, 0.125 step, full scale ffe0
// R2 - filter on: remote widens to 13 bits unsigned or 12 plus sign, 0.03125 step
// R3 - filtered signed remote is two's complement; plus one lsb 0008, minus fff8
// R4 - filtered unsigned remote: lsb 0008, top reading still ffe0
// R5 - local result is always 11-bit two's complement, 0.125 step
// R6 - enabled local channel compared to one limit, reset 85 degrees
// R7 - enabled remote one compared to two limits, reset 110 and 85
// R8 - remote two likewise with own limits, reset 110 and 85
// R9 - alarm one uses remote first limits; alarms two, three second; all local
// R10 - comparison outcomes kept in one status group per alarm output
// R11 - per-output masks decide which stored outcome drives each alarm
// R12 - status groups readable by software
// R13 - exceeding a limit sets the flag and activates unmasked alarms
// R14 - flags hold until temperature drops below limit minus shared hysteresis
// R15 - alarm pins active low, only pull low or release
// R16 - serial data pin only pulls low or releases
// R17 - diode fault reads -128 signed and 0 unsigned
// R18 - diode fault sets fault bit: bit 1 remote one, bit 0 remote two
// R19 - unfiltered remote also presented as 11-bit two's complement
// R20 - unused low bits of every temperature word read zero
// R21 - results saturate at full scale, never wrap
// R22 - filtered channel compares its filtered result
// R23 - comparisons run on each enabled conversion; disabled channels keep flags (a remote conversion with convFault set runs no comparison)
// R24 - set mask bit blocks flag; output is or of unmasked flags
// R25 - release threshold is limit minus hysteresis, clamped without wrap
`timescale 1ns/10ps
`default_nettype none
module tra_temp_alarm (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // conversion results: signed raw in 1/32 degree, one shared strobe plus channel select
   input  wire logic        convDone,
   input  wire logic [1:0]  convChannel,
   input  wire logic [17:0] convRaw,
   input  wire logic        convFault,
   input  wire logic        serialDataLow,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             overTempAlarmFirstOut,
   output logic             overTempAlarmFirstOe,
   output logic             overTempAlarmSecondOut,
   output logic             overTempAlarmSecondOe,
   output logic             overTempAlarmThirdOut,
   output logic             overTempAlarmThirdOe,
   output logic             serialDataOut,
   output logic             serialDataOe
);
   ////////////////////////////////////////////////////////////////////////////
   // convRaw: signed 18-bit value, units of 1/32 degree (range wider than formats)
   localparam logic [1:0] CH_LOCAL = 2'd0;
   localparam logic [1:0] CH_REM1  = 2'd1;
   localparam logic [1:0] CH_REM2  = 2'd2;

   logic [15:0] localTemp_q;
   logic [15:0] remSigned_q   [2];
   logic [15:0] remUnsigned_q [2];
   logic [4:0]  config_q;
   logic [1:0]  fault_q;
   logic [8:0]  alarmStat_q;
   logic [8:0]  mask_q;
   logic [7:0]  limitLocal_q;
   logic [7:0]  limitHigh_q [2];
   logic [7:0]  limitLow_q  [2];
   logic [7:0]  hyst_q;
   logic        serialSync1_q;
   logic        serialSync2_q;

   ////////////////////////////////////////////////////////////////////////////
   // formatting
   function automatic logic [15:0] fmtSigned(input logic [17:0] raw, input logic [15:0] keep);
      logic [15:0] v;
      v = 16'h0000;
      if ($signed(raw) > $signed(18'sh00fff))
         v = 16'h7fff;                                        // see R21
      else if ($signed(raw) < $signed(-18'sh01000))
         v = 16'h8000;                                        // see R21
      else
         v = {raw[12:0], 3'b000};                             // see R3
      fmtSigned = v & keep;                                   // see R20
   endfunction

   function automatic logic [15:0] fmtUnsigned(input logic [17:0] raw, input logic [15:0] keep);
      logic [15:0] v;
      v = 16'h0000;
      if (raw[17])
         v = 16'h0000;
      else if (raw > 18'h01fff)
         v = tra_pkg::UNSIGNED_FULL;                          // see R1
      else
         v = {raw[12:0], 3'b000} & keep;                      // see R4
      if (v > tra_pkg::UNSIGNED_FULL)
         v = tra_pkg::UNSIGNED_FULL;                          // see R21
      fmtUnsigned = v;                                        // see R20
   endfunction

   // over-limit with hysteresis: value in 1/32 degree, limit in degrees
   function automatic logic nextFlag(input logic flag, input logic [17:0] raw,
                                     input logic [7:0] lim, input logic [7:0] hy,
                                     input logic isSigned);
      logic signed [18:0] val;
      logic signed [18:0] limV;
      logic signed [18:0] relV;
      logic        [7:0]  rel;
      val  = $signed({raw[17], raw});
      limV = isSigned ? $signed({{6{lim[7]}}, lim, 5'b00000})
                      : $signed({6'b000000, lim, 5'b00000});
      rel  = (hy > lim && !isSigned) ? 8'h00 : lim - hy;       // see R25
      relV = isSigned ? limV - $signed({6'b000000, hy, 5'b00000})
                      : $signed({6'b000000, rel, 5'b00000});  // see R25
      if (val > limV)
         nextFlag = 1'b1;                                     // see R13
      else if (val < relV)
         nextFlag = 1'b0;                                     // see R14
      else
         nextFlag = flag;                                     // see R14
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // conversion path
   wire        isRemote  = (convChannel == CH_REM1) || (convChannel == CH_REM2);
   wire        remIdx    = (convChannel == CH_REM2);
   wire        enLocal   = config_q[tra_pkg::CFG_EN_LOCAL];
   wire        enRem     = remIdx ? config_q[tra_pkg::CFG_EN_REM2]
                                  : config_q[tra_pkg::CFG_EN_REM1];
   wire        filtOn    = remIdx ? config_q[tra_pkg::CFG_FILT_REM2]
                                  : config_q[tra_pkg::CFG_FILT_REM1];
   wire [15:0] remKeep   = filtOn ? tra_pkg::FINE_MASK : tra_pkg::COARSE_MASK; // see R2
   wire        takeLocal = convDone && (convChannel == CH_LOCAL) && enLocal;  // see R23
   wire        takeRem   = convDone && isRemote && enRem;                     // see R23
   // comparison uses unsaturated convRaw at the stored step (filtered when enabled)  // see R22
   wire [17:0] cmpRaw    = filtOn ? convRaw : {convRaw[17:2], 2'b00};
   wire        remFaultNow = takeRem && convFault;

   wire [15:0] localWord  = fmtSigned(convRaw, tra_pkg::COARSE_MASK);          // see R5
   wire [15:0] signedWord = remFaultNow ? tra_pkg::SIGNED_FAULT
                                        : fmtSigned(convRaw, remKeep);        // see R17 R19
   wire [15:0] unsWord    = remFaultNow ? 16'h0000 : fmtUnsigned(convRaw, remKeep); // see R17

   // status field index: local 0, rem1 1, rem2 2
   wire [1:0]  fld = convChannel;
   logic [8:0] alarmStat_d;
   always_comb
   begin
      alarmStat_d = alarmStat_q;
      if (takeLocal)
      begin
         alarmStat_d[tra_pkg::STAT_ALARM1_BASE] =
            nextFlag(alarmStat_q[tra_pkg::STAT_ALARM1_BASE], convRaw, limitLocal_q, hyst_q, 1'b1);
         alarmStat_d[tra_pkg::STAT_ALARM2_BASE] =
            nextFlag(alarmStat_q[tra_pkg::STAT_ALARM2_BASE], convRaw, limitLocal_q, hyst_q, 1'b1);
         alarmStat_d[tra_pkg::STAT_ALARM3_BASE] =
            nextFlag(alarmStat_q[tra_pkg::STAT_ALARM3_BASE], convRaw, limitLocal_q, hyst_q, 1'b1);
      end                                                     // see R6 R9
      else if (takeRem && !convFault)
      begin
         alarmStat_d[tra_pkg::STAT_ALARM1_BASE + fld] =
            nextFlag(alarmStat_q[tra_pkg::STAT_ALARM1_BASE + fld], cmpRaw,
                     limitHigh_q[remIdx], hyst_q, 1'b0);      // see R7 R8 R9
         alarmStat_d[tra_pkg::STAT_ALARM2_BASE + fld] =
            nextFlag(alarmStat_q[tra_pkg::STAT_ALARM2_BASE + fld], cmpRaw,
                     limitLow_q[remIdx], hyst_q, 1'b0);
         alarmStat_d[tra_pkg::STAT_ALARM3_BASE + fld] =
            nextFlag(alarmStat_q[tra_pkg::STAT_ALARM3_BASE + fld], cmpRaw,
                     limitLow_q[remIdx], hyst_q, 1'b0);
      end                                                     // see R10
   end

   // mask bit set blocks the flag  // see R11 R24
   wire [8:0] unmasked = alarmStat_q & ~mask_q;
   wire alarm1 = |unmasked[tra_pkg::STAT_ALARM1_BASE +: 3];
   wire alarm2 = |unmasked[tra_pkg::STAT_ALARM2_BASE +: 3];
   wire alarm3 = |unmasked[tra_pkg::STAT_ALARM3_BASE +: 3];

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   wire apbWrite = psel && penable && pwrite;
   wire apbRead  = psel && !pwrite;
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a <= tra_pkg::OFS_ID) && (a[1:0] == 2'b00);
   endfunction
   logic [31:0] readMux;
   always_comb
   begin
      readMux = 32'h0000_0000;
      case (paddr)
         tra_pkg::OFS_LOCAL_TEMP:  readMux = {16'h0000, localTemp_q};
         tra_pkg::OFS_REM1_SIGNED: readMux = {16'h0000, remSigned_q[0]};
         tra_pkg::OFS_REM2_SIGNED: readMux = {16'h0000, remSigned_q[1]};
         tra_pkg::OFS_REM1_UNSIGN: readMux = {16'h0000, remUnsigned_q[0]};
         tra_pkg::OFS_REM2_UNSIGN: readMux = {16'h0000, remUnsigned_q[1]};
         tra_pkg::OFS_CONFIG:      readMux = {27'h0, config_q};
         tra_pkg::OFS_FAULT_STAT:  readMux = {30'h0, fault_q};
         tra_pkg::OFS_ALARM_STAT:  readMux = {23'h0, alarmStat_q};   // see R12
         tra_pkg::OFS_MASK:        readMux = {23'h0, mask_q};
         tra_pkg::OFS_LIMIT_LOCAL: readMux = {24'h0, limitLocal_q};
         tra_pkg::OFS_LIMIT_REM1:  readMux = {16'h0, limitLow_q[0], limitHigh_q[0]};
         tra_pkg::OFS_LIMIT_REM2:  readMux = {16'h0, limitLow_q[1], limitHigh_q[1]};
         tra_pkg::OFS_HYST:        readMux = {24'h0, hyst_q};
         tra_pkg::OFS_ID:          readMux = {16'h0, tra_pkg::ID_VALUE};
         default:                  readMux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         localTemp_q      <= 16'h0000;
         remSigned_q[0]   <= 16'h0000;
         remSigned_q[1]   <= 16'h0000;
         remUnsigned_q[0] <= 16'h0000;
         remUnsigned_q[1] <= 16'h0000;
         fault_q          <= 2'b00;
         alarmStat_q      <= 9'h000;
      end
      else
      begin
         alarmStat_q <= alarmStat_d;
         if (takeLocal)
            localTemp_q <= localWord;
         if (takeRem)
         begin
            remSigned_q[remIdx]   <= signedWord;
            remUnsigned_q[remIdx] <= unsWord;
            fault_q[remIdx ? tra_pkg::FAULT_REM2_BIT : tra_pkg::FAULT_REM1_BIT]
               <= convFault;                                  // see R18
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         config_q       <= tra_pkg::CONFIG_RESET;
         mask_q         <= tra_pkg::MASK_RESET;
         limitLocal_q   <= tra_pkg::LIMIT_LOCAL_RESET;        // see R6
         limitHigh_q[0] <= tra_pkg::LIMIT_HIGH_RESET;         // see R7
         limitHigh_q[1] <= tra_pkg::LIMIT_HIGH_RESET;         // see R8
         limitLow_q[0]  <= tra_pkg::LIMIT_LOW_RESET;
         limitLow_q[1]  <= tra_pkg::LIMIT_LOW_RESET;
         hyst_q         <= tra_pkg::HYST_RESET;
      end
      else if (apbWrite)
      begin
         case (paddr)
            tra_pkg::OFS_CONFIG:      config_q     <= pwdata[4:0];
            tra_pkg::OFS_MASK:        mask_q       <= pwdata[8:0];
            tra_pkg::OFS_LIMIT_LOCAL: limitLocal_q <= pwdata[7:0];
            tra_pkg::OFS_LIMIT_REM1:
            begin
               limitHigh_q[0] <= pwdata[7:0];
               limitLow_q[0]  <= pwdata[15:8];
            end
            tra_pkg::OFS_LIMIT_REM2:
            begin
               limitHigh_q[1] <= pwdata[7:0];
               limitLow_q[1]  <= pwdata[15:8];
            end
            tra_pkg::OFS_HYST:        hyst_q       <= pwdata[7:0];
            default:                  hyst_q       <= hyst_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prdata                 <= 32'h0000_0000;
         pready                 <= 1'b0;
         pslverr                <= 1'b0;
         overTempAlarmFirstOut  <= 1'b0;
         overTempAlarmFirstOe   <= 1'b0;
         overTempAlarmSecondOut <= 1'b0;
         overTempAlarmSecondOe  <= 1'b0;
         overTempAlarmThirdOut  <= 1'b0;
         overTempAlarmThirdOe   <= 1'b0;
         serialDataOut          <= 1'b0;
         serialDataOe           <= 1'b0;
         serialSync1_q          <= 1'b0;
         serialSync2_q          <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !isMapped(paddr);
         if (apbRead && !penable)
            prdata <= readMux;
         // open drain: drive low only, never high  // see R15
         overTempAlarmFirstOut  <= 1'b0;
         overTempAlarmFirstOe   <= alarm1;                    // see R13
         overTempAlarmSecondOut <= 1'b0;
         overTempAlarmSecondOe  <= alarm2;
         overTempAlarmThirdOut  <= 1'b0;
         overTempAlarmThirdOe   <= alarm3;
         serialSync1_q          <= serialDataLow;
         serialSync2_q          <= serialSync1_q;
         serialDataOut          <= 1'b0;                      // see R16
         serialDataOe           <= serialSync2_q;             // see R16
      end
   end
endmodule
`default_nettype wire

// [sim/tra_temp_alarm_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module tra_temp_alarm_sva (
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       convDone,
   input wire logic [1:0] convChannel,
   input wire logic       convFault,
   input wire logic       serialDataLow,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       overTempAlarmFirstOut,
   input wire logic       overTempAlarmFirstOe,
   input wire logic       overTempAlarmSecondOut,
   input wire logic       overTempAlarmSecondOe,
   input wire logic       overTempAlarmThirdOut,
   input wire logic       overTempAlarmThirdOe,
   input wire logic       serialDataOut,
   input wire logic       serialDataOe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire logic [2:0] alarmOe = {overTempAlarmThirdOe, overTempAlarmSecondOe, overTempAlarmFirstOe};
   wire logic       regWrite = psel && penable && pwrite;
   sequence quietCycle;
      !convDone && !regWrite;
   endsequence
   sequence faultConv;
      convDone && convFault && convChannel != 2'h0 && !regWrite;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_alarm_never_high: assert property (
      !overTempAlarmFirstOut && !overTempAlarmSecondOut && !overTempAlarmThirdOut)
      else $error("alarm pin driven high");
   a_serial_never_high: assert property (!serialDataOut)
      else $error("serial data pin driven high");
   a_serial_delay: assert property (
      $past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n)
      |-> serialDataOe == $past(serialDataLow, 3))
      else $error("serial pull-down not three cycles after request");
   a_setup_gets_ready: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_error_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_alarm_has_cause: assert property ($changed(alarmOe)
      |-> $past(convDone) || $past(convDone, 2) || $past(regWrite) || $past(regWrite, 2))
      else $error("alarm changed with no conversion or write");
   a_fault_keeps_alarm: assert property (
      quietCycle ##1 faultConv ##1 quietCycle |=> $stable(alarmOe))
      else $error("diode fault changed alarm state");
endmodule
bind tra_temp_alarm tra_temp_alarm_sva chk_u (
   .clk_sys(clk_sys), .reset_n(reset_n), .convDone(convDone), .convChannel(convChannel),
   .convFault(convFault), .serialDataLow(serialDataLow), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .overTempAlarmFirstOut(overTempAlarmFirstOut), .overTempAlarmFirstOe(overTempAlarmFirstOe),
   .overTempAlarmSecondOut(overTempAlarmSecondOut),
   .overTempAlarmSecondOe(overTempAlarmSecondOe),
   .overTempAlarmThirdOut(overTempAlarmThirdOut), .overTempAlarmThirdOe(overTempAlarmThirdOe),
   .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));
`default_nettype wire

// [sim/tra_alarm_sink.sv]
`timescale 1ns/10ps
`default_nettype none
module tra_alarm_sink (
   input  wire logic [2:0] alarmOut,
   input  wire logic [2:0] alarmOe,
   input  wire logic       serialOut,
   input  wire logic       serialOe,
   output logic      [2:0] alarmPin,
   output logic            serialPin
);
   // external pull-ups hold released pins high
   assign alarmPin  = ~alarmOe | alarmOut;
   assign serialPin = ~serialOe | serialOut;
endmodule
`default_nettype wire

// [sim/tb_tra_temp_alarm.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_tra_temp_alarm;
   logic        clk_sys;
   logic        reset_n;
   logic        convDone;
   logic [1:0]  convChannel;
   logic [17:0] convRaw;
   logic        convFault;
   logic        serialDataLow;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   wire logic [31:0] prdata;
   wire logic        pready;
   wire logic        pslverr;
   wire logic [2:0]  alarmOut;
   wire logic [2:0]  alarmOe;
   wire logic        serialDataOut;
   wire logic        serialDataOe;
   wire logic [2:0]  alarmPin;
   wire logic        serialPin;
   int          miscompares;
   int          totalChecks;
   tra_temp_alarm dut_u (
      .clk_sys(clk_sys), .reset_n(reset_n), .convDone(convDone), .convChannel(convChannel),
      .convRaw(convRaw), .convFault(convFault), .serialDataLow(serialDataLow), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .overTempAlarmFirstOut(alarmOut[0]), .overTempAlarmFirstOe(alarmOe[0]),
      .overTempAlarmSecondOut(alarmOut[1]), .overTempAlarmSecondOe(alarmOe[1]),
      .overTempAlarmThirdOut(alarmOut[2]), .overTempAlarmThirdOe(alarmOe[2]),
      .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));
   tra_alarm_sink sink_u (.alarmOut(alarmOut), .alarmOe(alarmOe), .serialOut(serialDataOut),
      .serialOe(serialDataOe), .alarmPin(alarmPin), .serialPin(serialPin));
   ////////////////////////////////////////////////////////////////////////
   task automatic giveVerdict();
      if (miscompares == 0 && totalChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      // ready, data and error are taken at the rising edge only
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (pready !== 1'b1)
      begin
         miscompares++;
         giveVerdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      check(what, exp, rd);
   endtask
   task automatic conv(input logic [1:0] ch, input logic [17:0] raw, input logic flt);
      @(posedge clk_sys);
      convDone <= 1'b1;
      convChannel <= ch;
      convRaw <= raw;
      convFault <= flt;
      @(posedge clk_sys);
      convDone <= 1'b0;
      convFault <= 1'b0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic pinChk(input logic [2:0] exp);
      check("alarm pins", {29'h0, exp}, {29'h0, alarmPin});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic testResetValues();
      logic [31:0] rd;
      logic        err;
      pinChk(3'b111);
      rdChk(tra_pkg::OFS_LIMIT_LOCAL, 32'h55, "local limit");
      rdChk(tra_pkg::OFS_LIMIT_REM1, 32'h556e, "rem1 limits");
      rdChk(tra_pkg::OFS_LIMIT_REM2, 32'h556e, "rem2 limits");
      rdChk(tra_pkg::OFS_MASK, {23'h0, tra_pkg::MASK_RESET}, "mask");
      rdChk(tra_pkg::OFS_ID, {16'h0, tra_pkg::ID_VALUE}, "id");
      wr(tra_pkg::OFS_LOCAL_TEMP, 32'h1234);
      rdChk(tra_pkg::OFS_LOCAL_TEMP, 32'h0, "read-only temp");
      apb(1'b0, 8'h38, 32'h0, rd, err);
      check("unmapped err", 32'h1, {31'h0, err});
   endtask
   task automatic testFormats();
      conv(2'h1, 18'h00001, 1'b0);
      rdChk(tra_pkg::OFS_REM1_SIGNED, 32'h0008, "fine signed lsb");
      rdChk(tra_pkg::OFS_REM1_UNSIGN, 32'h0008, "fine unsigned lsb");
      conv(2'h2, 18'h3ffff, 1'b0);
      rdChk(tra_pkg::OFS_REM2_SIGNED, 32'hfff8, "fine signed minus");
      conv(2'h1, 18'h02328, 1'b0);
      rdChk(tra_pkg::OFS_REM1_UNSIGN, 32'hffe0, "fine unsigned top");
      rdChk(tra_pkg::OFS_REM1_SIGNED, 32'h7ff8, "fine signed top");
      conv(2'h0, 18'h00001, 1'b0);
      rdChk(tra_pkg::OFS_LOCAL_TEMP, 32'h0, "local below lsb");
      conv(2'h0, 18'h3fffc, 1'b0);
      rdChk(tra_pkg::OFS_LOCAL_TEMP, 32'hffe0, "local minus lsb");
      wr(tra_pkg::OFS_CONFIG, 32'h07);
      conv(2'h1, 18'h00001, 1'b0);
      rdChk(tra_pkg::OFS_REM1_SIGNED, 32'h0, "coarse below lsb");
      conv(2'h1, 18'h3fffc, 1'b0);
      rdChk(tra_pkg::OFS_REM1_SIGNED, 32'hffe0, "coarse signed minus");
      rdChk(tra_pkg::OFS_REM1_UNSIGN, 32'h0, "coarse unsigned clamp");
      conv(2'h2, 18'h02328, 1'b0);
      rdChk(tra_pkg::OFS_REM2_UNSIGN, 32'hffe0, "coarse unsigned top");
   endtask
   task automatic testAlarms();
      wr(tra_pkg::OFS_MASK, 32'h0);
      conv(2'h1, 18'h00280, 1'b0);
      conv(2'h2, 18'h00280, 1'b0);
      conv(2'h0, 18'h00ac0, 1'b0);
      pinChk(3'b000);
      rdChk(tra_pkg::OFS_ALARM_STAT, 32'h49, "local status");
      conv(2'h0, 18'h00a00, 1'b0);
      pinChk(3'b000);
      conv(2'h0, 18'h009e0, 1'b0);
      pinChk(3'b111);
      conv(2'h1, 18'h00c80, 1'b0);
      pinChk(3'b001);
      wr(tra_pkg::OFS_MASK, 32'h010);
      // mask lands at the write edge, pins one edge later
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      pinChk(3'b011);
      rdChk(tra_pkg::OFS_ALARM_STAT, 32'h90, "masked status");
      conv(2'h1, 18'h00f00, 1'b0);
      pinChk(3'b010);
      conv(2'h1, 18'h00000, 1'b1);
      pinChk(3'b010);
      rdChk(tra_pkg::OFS_REM1_SIGNED, 32'h8000, "fault signed");
      rdChk(tra_pkg::OFS_REM1_UNSIGN, 32'h0, "fault unsigned");
      conv(2'h2, 18'h00000, 1'b1);
      rdChk(tra_pkg::OFS_FAULT_STAT, 32'h3, "fault bits");
      wr(tra_pkg::OFS_CONFIG, 32'h05);
      conv(2'h1, 18'h00280, 1'b0);
      pinChk(3'b010);
      rdChk(tra_pkg::OFS_ALARM_STAT, 32'h92, "disabled status");
   endtask
   task automatic testSerialPin();
      @(posedge clk_sys);
      serialDataLow <= 1'b1;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      check("serial pin low", 32'h0, {31'h0, serialPin});
      @(posedge clk_sys);
      serialDataLow <= 1'b0;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      check("serial pin released", 32'h1, {31'h0, serialPin});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial
   begin
      {reset_n, convDone, convChannel, convRaw, convFault, serialDataLow} = '0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      miscompares = 0;
      totalChecks = 0;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      testResetValues();
      testFormats();
      testAlarms();
      testSerialPin();
      giveVerdict();
   end
endmodule
`default_nettype wire
